// ---- rtl/asram_pkg.sv ----
// Constants for the asynchronous static memory controller.
// Assumes a 125 MHz system clock; times are in ns and converted here.
package asram_pkg;
    localparam int ADDR_W       = 18;
    localparam int DATA_W       = 4;
    localparam int CLK_PERIOD_NS = 8;
    // Device timing figures (slowest grade, ns)
    localparam int T_RC_NS      = 35;  // Read cycle time
    localparam int T_AA_NS      = 35;  // Address to data valid
    localparam int T_PWE_NS     = 25;  // Write strobe pulse width
    localparam int T_SD_NS      = 20;  // Data setup to write end
    localparam int T_HZWE_NS    = 10;  // Strobe low to high impedance
    localparam int T_HZOE_NS    = 10;  // Output enable high to high impedance
    // Least times round up to whole cycles
    localparam int RD_CYC   = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WR_CYC   = (((T_PWE_NS > T_HZWE_NS + T_SD_NS) ? T_PWE_NS
                               : T_HZWE_NS + T_SD_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W    = 4;
endpackage : asram_pkg

// ---- rtl/asram_cycle_timer.sv ----
// Down counter that times the strobe, access, turnaround and recovery phases.
// Assumes the caller loads it with a count of at least one.
module asram_cycle_timer #(
    parameter int CNT_W = 4
) (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             load,      // Load a new count
    input  wire logic [CNT_W-1:0] load_val,  // Count to load
    output logic                  done       // High when count is zero
);
    logic [CNT_W-1:0] cnt_reg;

    // Count down to zero and hold
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign done = (cnt_reg == '0);
endmodule // asram_cycle_timer

// ---- rtl/asram_ctrl.sv ----
// Controller that drives an asynchronous 256K x 4 static memory by its pins.
// Assumes a single-word request port and a separately controlled supply.
module asram_ctrl (
    input  wire logic                          sys_clk,    // System clock
    input  wire logic                          rst_n,      // Async reset, active low
    input  wire logic                          req_valid,  // Request present
    input  wire logic                          req_write,  // 1 write, 0 read
    input  wire logic [asram_pkg::ADDR_W-1:0]  req_addr,   // Word address
    input  wire logic [asram_pkg::DATA_W-1:0]  req_wdata,  // Write data
    input  wire logic                          retain_req, // Ask for supply retention
    output logic                               req_ready,  // Request taken this cycle
    output logic                               rsp_valid,  // Read data valid pulse
    output logic [asram_pkg::DATA_W-1:0]       rsp_rdata,  // Read data
    output logic                               retain_ok,  // Supply may be lowered
    output logic [asram_pkg::ADDR_W-1:0]       mem_addr,   // Address pins
    output logic                               mem_sel_n,  // Chip select, low active
    output logic                               mem_oe_n,   // Output enable, low active
    output logic                               mem_we_n,   // Write strobe, low active
    output logic [asram_pkg::DATA_W-1:0]       mem_dq_o,   // Data out
    output logic                               mem_dq_oe,  // Data out enable
    input  wire logic [asram_pkg::DATA_W-1:0]  mem_dq_i    // Data in
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_ADDR, ST_RD_WAIT, ST_RD_TURN, ST_WR_STRB, ST_WR_END, ST_RETAIN, ST_RECOVER
    } asram_state_type;

    typedef struct packed {
        asram_state_type                  state;
        logic [asram_pkg::ADDR_W-1:0]     addr;
        logic                             sel_n;
        logic                             oe_n;
        logic                             we_n;
        logic [asram_pkg::DATA_W-1:0]     dq_o;
        logic                             dq_oe;
        logic                             ready;
        logic                             rvalid;
        logic [asram_pkg::DATA_W-1:0]     rdata;
        logic                             retain;
    } asram_regs_type;

    asram_regs_type r_reg, r_next;
    logic                           tmr_load;
    logic [asram_pkg::CNT_W-1:0]    tmr_val;
    logic                           tmr_done;

    // Phase timer
    asram_cycle_timer #(.CNT_W(asram_pkg::CNT_W)) asram_cycle_timer_i (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // Next-state logic for the pin sequencer
    always_comb begin
        r_next        = r_reg;
        r_next.ready  = 1'b0;
        r_next.rvalid = 1'b0;
        tmr_load      = 1'b0;
        tmr_val       = '0;
        case (r_reg.state)
            ST_IDLE: begin
                r_next.sel_n = 1'b1;
                r_next.oe_n  = 1'b1;
                r_next.we_n  = 1'b1;
                r_next.dq_oe = 1'b0;
                if (retain_req) begin
                    r_next.state  = ST_RETAIN;
                    r_next.retain = 1'b1;
                end else if (req_valid && !r_reg.ready) begin
                    r_next.ready = 1'b1;
                    r_next.addr  = req_addr;
                    if (req_write) begin
                        r_next.dq_o  = req_wdata;
                        r_next.dq_oe = 1'b1;
                        r_next.sel_n = 1'b0;
                        r_next.we_n  = 1'b0;
                        r_next.state = ST_WR_STRB;
                        tmr_load     = 1'b1;
                        tmr_val      = asram_pkg::CNT_W'(asram_pkg::WR_CYC - 1);
                    end else begin
                        r_next.state = ST_RD_ADDR;
                    end
                end
            end
            ST_RD_ADDR: begin
                r_next.sel_n = 1'b0;
                r_next.oe_n  = 1'b0;
                r_next.dq_oe = 1'b0;
                r_next.state = ST_RD_WAIT;
                tmr_load     = 1'b1;
                tmr_val      = asram_pkg::CNT_W'(asram_pkg::RD_CYC - 1);
            end
            ST_RD_WAIT: begin
                if (tmr_done) begin
                    r_next.rdata  = mem_dq_i;
                    r_next.rvalid = 1'b1;
                    r_next.sel_n  = 1'b1;
                    r_next.oe_n   = 1'b1;
                    r_next.state  = ST_RD_TURN;
                    tmr_load      = 1'b1;
                    tmr_val       = asram_pkg::CNT_W'(asram_pkg::TURN_CYC);
                end
            end
            ST_RD_TURN: begin
                if (tmr_done) begin
                    r_next.state = ST_IDLE;
                end
            end
            ST_WR_STRB: begin
                if (tmr_done) begin
                    // Strobe and select rise together; data held one more cycle
                    r_next.we_n  = 1'b1;
                    r_next.sel_n = 1'b1;
                    r_next.state = ST_WR_END;
                end
            end
            ST_WR_END: begin
                r_next.dq_oe = 1'b0;
                r_next.state = ST_IDLE;
            end
            ST_RETAIN: begin
                r_next.sel_n = 1'b1;
                if (!retain_req) begin
                    r_next.retain = 1'b0;
                    r_next.state  = ST_RECOVER;
                    tmr_load      = 1'b1;
                    tmr_val       = asram_pkg::CNT_W'(asram_pkg::REC_CYC);
                end
            end
            ST_RECOVER: begin
                if (tmr_done) begin
                    r_next.state = ST_IDLE;
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.sel_n <= 1'b1;
            r_reg.oe_n  <= 1'b1;
            r_reg.we_n  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Every output comes straight from the state register
    assign req_ready = r_reg.ready;
    assign rsp_valid = r_reg.rvalid;
    assign rsp_rdata = r_reg.rdata;
    assign retain_ok = r_reg.retain;
    assign mem_addr  = r_reg.addr;
    assign mem_sel_n = r_reg.sel_n;
    assign mem_oe_n  = r_reg.oe_n;
    assign mem_we_n  = r_reg.we_n;
    assign mem_dq_o  = r_reg.dq_o;
    assign mem_dq_oe = r_reg.dq_oe;

    // Checks on pin behaviour
    no_contend_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mem_oe_n |-> !mem_dq_oe) else $error("data driven during read");
    wr_data_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!mem_sel_n && !mem_we_n) |-> mem_dq_oe) else $error("write without data");
    rd_strobe_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mem_oe_n |-> (mem_we_n && !mem_sel_n)) else $error("read with strobe low");
    sequence wr_start_s;
        $fell(mem_we_n);
    endsequence
    sequence wr_hold_s;
        !mem_we_n [*4];
    endsequence
    wr_len_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_start_s |-> wr_hold_s ##1 mem_we_n) else $error("write length wrong");
    end_together_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(mem_we_n) |-> $rose(mem_sel_n)) else $error("select and strobe split");
    hold_data_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(mem_we_n) |-> mem_dq_oe && $stable(mem_dq_o)) else $error("data hold lost");
    addr_first_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(mem_sel_n) && mem_we_n) |-> $stable(mem_addr)) else $error("address late");
    retain_sel_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        retain_ok |-> mem_sel_n) else $error("selected in retention");
    standby_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r_reg.state == ST_IDLE) |-> mem_sel_n) else $error("idle but selected");
    // Strobe never falls without select, so no write starts half-formed
    wr_sel_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mem_we_n |-> !mem_sel_n) else $error("strobe low while deselected");
    // Address must not move while the memory is reading it
    rd_addr_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mem_oe_n |-> $stable(mem_addr)) else $error("address moved in read");
    // After a read the memory needs time to float the bus before we drive it
    sequence rd_end_s;
        $rose(mem_oe_n);
    endsequence
    sequence bus_quiet_s;
        !mem_dq_oe [*4];
    endsequence
    turn_gap_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_end_s |-> bus_quiet_s) else $error("bus driven too soon after read");
    // Once the supply is back the memory stays deselected for a read cycle
    sequence rec_start_s;
        $fell(retain_ok);
    endsequence
    sequence rec_quiet_s;
        mem_sel_n [*5];
    endsequence
    rec_wait_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        rec_start_s |-> rec_quiet_s) else $error("selected during recovery");
endmodule // asram_ctrl

// ---- verification/asram_mem_model.sv ----
// Behavioural model of the 256K x 4 static memory on the pin side.
// Assumes its controls come from registers of one clock.
module asram_mem_model (
    input  wire logic [17:0] addr,    // Word address
    input  wire logic        sel_n,   // Chip select
    input  wire logic        oe_n,    // Output enable
    input  wire logic        we_n,    // Write strobe
    input  wire logic [3:0]  dq_in,   // Level on the data bus
    output logic      [3:0]  dq_out,  // Value the model puts out
    output logic             dq_en    // High while the model drives
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  mem [0:262143];
    logic [17:0] wa;
    logic [3:0]  wd;
    logic [3:0]  rd;
    wire         wact = !sel_n && !we_n;
    // Start from a known all-zero array
    initial foreach (mem[i]) mem[i] = 4'h0;
    // Follow address and data while the write overlap lasts
    always @* begin
        if (wact) begin
            wa = addr;
            wd = dq_in;
        end
    end
    // Store at the first rise that ends the overlap
    always @(negedge wact) mem[wa] = wd;
    // Drive only in a read; a released bus shows the inverse word
    assign dq_en = !sel_n && !oe_n && we_n;
    always @* begin
        rd = mem[addr];
        dq_out = dq_en ? rd : ~rd;
    end
endmodule // asram_mem_model

// ---- verification/async_sram_256k_by_4_bench.sv ----
// Self-checking bench for the static memory controller.
// Assumes the memory model stands on the pin side.
module async_sram_256k_by_4_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, retain_req = 0;
    logic [17:0] req_addr = '0, mem_addr;
    logic [3:0]  req_wdata = '0, rsp_rdata, mem_dq_o, mdl_dq, dq_wire;
    logic        req_ready, rsp_valid, retain_ok, mem_sel_n, mem_oe_n, mem_we_n;
    logic        mem_dq_oe, mdl_en;
    int          fails = 0, n_tests = 0, cyc = 0;
    realtime     t_rest = -1000;
    always #4 sys_clk = ~sys_clk;
    assign dq_wire = mem_dq_oe ? mem_dq_o : mdl_dq;
    asram_ctrl asram_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .retain_ok(retain_ok), .mem_addr(mem_addr),
        .mem_sel_n(mem_sel_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
        .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(dq_wire));
    asram_mem_model asram_mem_model_i (.addr(mem_addr), .sel_n(mem_sel_n), .oe_n(mem_oe_n),
        .we_n(mem_we_n), .dq_in(dq_wire), .dq_out(mdl_dq), .dq_en(mdl_en));
    task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    // Watch the bus on every cycle out of reset, and the select line in retention
    always @(negedge sys_clk) begin
        if (rst_n) chk("bus contention", 0, mem_dq_oe & mdl_en);
        if (retain_ok) chk("select in retention", 1, mem_sel_n);
    end
    // Select must wait one read cycle after the supply returns
    always @(negedge mem_sel_n) chk("recovery", 1, ($realtime - t_rest) >= asram_pkg::T_RC_NS);
    task automatic xfer(logic wr, logic [17:0] a, logic [3:0] d, output logic [3:0] q);
        int n = 0;
        // Let an edge pass so a request never rises in the step it fell
        @(negedge sys_clk);
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        do @(negedge sys_clk); while (req_ready !== 1 && ++n < 20);
        chk("request taken", 1, req_ready);
        req_valid = 0;
        n = 0;
        while (!wr && rsp_valid !== 1 && ++n < 20) @(negedge sys_clk);
        if (!wr) chk("read answer", 1, rsp_valid);
        q = rsp_rdata;
    endtask
    task automatic test_rw();
        logic [17:0] a [4] = '{18'h00000, 18'h3ffff, 18'h155aa, 18'h2aa55};
        logic [3:0]  q;
        foreach (a[i]) xfer(1, a[i], a[i][3:0] ^ 4'h9, q);
        foreach (a[i]) begin
            xfer(0, a[i], 4'h0, q);
            chk("read data", a[i][3:0] ^ 4'h9, q);
        end
        xfer(1, 18'h3ffff, 4'h1, q);
        xfer(0, 18'h3ffff, 4'h0, q);
        chk("overwrite", 4'h1, q);
        $display("Test rw done");
    endtask
    task automatic test_retain();
        logic [3:0] q;
        int         n = 0;
        xfer(1, 18'h00123, 4'hb, q);
        // Retention is granted only once the write has finished
        retain_req = 1;
        do @(negedge sys_clk); while (retain_ok !== 1 && ++n < 20);
        chk("retain granted", 1, retain_ok);
        req_valid = 1;
        req_write = 0;
        req_addr = 18'h00123;
        repeat (6) begin
            @(negedge sys_clk);
            chk("refused in retention", 0, req_ready);
        end
        retain_req = 0;
        t_rest = $realtime;
        xfer(0, 18'h00123, 4'h0, q);
        chk("kept in retention", 4'hb, q);
        $display("Test retain done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1;
        chk("idle select", 1, mem_sel_n);
        @(negedge sys_clk);
        test_rw();
        test_retain();
        give_verdict();
    end
endmodule // async_sram_256k_by_4_bench
